// *** design/gp_page_regs.sv ***
// Shared general-purpose register page behind an Avalon-MM slave
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module gp_page_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Per-port software reset
  input wire logic [3:0] port_soft_rst,
  // Avalon-MM slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // GPIO pins
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  // Mode pin level and interrupt sources
  input wire logic coma_in,
  input wire logic [15:0] int_status_in,
  // Per-port page status
  output logic [3:0] page_is_gp
);

  typedef struct packed {
    logic [3:0][15:0] page_sel;
    logic [3:0] gp_flag;
    logic wait_req;
    logic [31:0] rdata;
    logic [15:0] pin_src;
    logic [15:0] ctrl2;
    logic [15:0] gp_out;
    logic [15:0] gp_oe;
    logic [15:0] micro;
    logic [15:0] mac_mode;
    logic [15:0] led_enh;
  } state_t;

  state_t s;
  state_t next_s;

  // Decoded request
  logic [1:0] req_port;
  logic [4:0] req_idx;
  logic req_aligned;
  logic [15:0] req_page;
  logic [15:0] rword;
  logic [15:0] wword;
  logic commit;

  // True when an index is a live register of the shared page
  function automatic logic gp_hit(
    input logic [15:0] page,
    input logic [4:0] idx
  );
    logic live;
    live = 1'b0;
    if (page != gp_page_pkg::CODE_GP) begin
      live = 1'b0;
    end else if (idx == gp_page_pkg::IDX_PIN_SRC) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_CTRL2) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_GP_IN) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_GP_OUT) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_GP_OE) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_MICRO) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_MAC_MODE) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_LED_ENH) begin
      live = 1'b1;
    end else if (idx == gp_page_pkg::IDX_INT_STAT) begin
      live = 1'b1;
    end else begin
      live = 1'b0;
    end
    return live;
  endfunction : gp_hit

  // Byte-lane merge of a 16-bit register with new write data
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] wdata,
    input logic [1:0] be
  );
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge

  // Address split: port, word index, alignment
  always_comb begin
    req_port = avs_address[gp_page_pkg::ADDR_PORT_LSB +: gp_page_pkg::PORT_W];
    req_idx = avs_address[gp_page_pkg::ADDR_IDX_LSB +: gp_page_pkg::IDX_W];
    req_aligned = (avs_address[gp_page_pkg::ADDR_IDX_LSB-1:0] == 2'h0);
    req_page = s.page_sel[req_port];
  end

  // Read mux; every port sees the same page storage
  always_comb begin
    rword = gp_page_pkg::RST_ZERO;
    if (!req_aligned) begin
      rword = gp_page_pkg::RST_ZERO;
    end else if (req_idx == gp_page_pkg::IDX_PAGE) begin
      rword = req_page;
    end else if (!gp_hit(req_page, req_idx)) begin
      rword = gp_page_pkg::RST_ZERO;
    end else begin
      case (req_idx)
        gp_page_pkg::IDX_PIN_SRC: begin
          rword = s.pin_src;
        end
        gp_page_pkg::IDX_CTRL2: begin
          rword = s.ctrl2 & gp_page_pkg::CTRL2_WR_MASK;
          rword[gp_page_pkg::CTRL2_PIN_BIT] = coma_in;
        end
        gp_page_pkg::IDX_GP_IN: begin
          rword = {8'h00, gpio_in} & gp_page_pkg::GP_IN_MASK;
        end
        gp_page_pkg::IDX_GP_OUT: begin
          rword = s.gp_out;
        end
        gp_page_pkg::IDX_GP_OE: begin
          rword = s.gp_oe;
        end
        gp_page_pkg::IDX_MICRO: begin
          rword = s.micro;
        end
        gp_page_pkg::IDX_MAC_MODE: begin
          rword = s.mac_mode;
        end
        gp_page_pkg::IDX_LED_ENH: begin
          rword = s.led_enh;
        end
        gp_page_pkg::IDX_INT_STAT: begin
          rword = int_status_in;
        end
        default: begin
          rword = gp_page_pkg::RST_ZERO;
        end
      endcase
    end
  end

  // Low half of the write data (byte lanes applied later in merge), and the commit edge
  always_comb begin
    wword = avs_writedata[gp_page_pkg::REG_W-1:0];
    commit = avs_write && !s.wait_req && req_aligned;
  end

  // Next state: bus handshake, page select, shared page registers
  always_comb begin
    next_s = s;
    // Port soft reset only returns that port to the main page
    for (int p = 0; p < gp_page_pkg::NUM_PORTS; p++) begin
      if (port_soft_rst[p]) begin
        next_s.page_sel[p] = gp_page_pkg::CODE_MAIN;
      end
    end
    // One wait cycle, then a single ready cycle per request
    if ((avs_read || avs_write) && s.wait_req) begin
      next_s.wait_req = 1'b0;
      next_s.rdata = {16'h0000, rword};
    end else begin
      next_s.wait_req = 1'b1;
    end
    // Writes take effect at the edge that sees waitrequest low
    if (commit) begin
      if (req_idx == gp_page_pkg::IDX_PAGE) begin
        // Any code is stored; only 0x0010 opens the shared page
        next_s.page_sel[req_port] =
          merge(req_page, wword, avs_byteenable[1:0]);
      end else if (gp_hit(req_page, req_idx)) begin
        case (req_idx)
          gp_page_pkg::IDX_PIN_SRC: begin
            next_s.pin_src = merge(s.pin_src, wword, avs_byteenable[1:0]);
          end
          gp_page_pkg::IDX_CTRL2: begin
            next_s.ctrl2 = merge(s.ctrl2, wword, avs_byteenable[1:0])
              & gp_page_pkg::CTRL2_WR_MASK;
          end
          gp_page_pkg::IDX_GP_OUT: begin
            next_s.gp_out = merge(s.gp_out, wword, avs_byteenable[1:0]);
          end
          gp_page_pkg::IDX_GP_OE: begin
            next_s.gp_oe = merge(s.gp_oe, wword, avs_byteenable[1:0]);
          end
          gp_page_pkg::IDX_MICRO: begin
            next_s.micro = merge(s.micro, wword, avs_byteenable[1:0]);
          end
          gp_page_pkg::IDX_MAC_MODE: begin
            next_s.mac_mode = merge(s.mac_mode, wword, avs_byteenable[1:0]);
          end
          gp_page_pkg::IDX_LED_ENH: begin
            next_s.led_enh = merge(s.led_enh, wword, avs_byteenable[1:0]);
          end
          default: begin
            // Input and interrupt status are read-only
            next_s.micro = s.micro;
          end
        endcase
      end
    end
    // Page status flag follows the stored code
    for (int p = 0; p < gp_page_pkg::NUM_PORTS; p++) begin
      next_s.gp_flag[p] = (next_s.page_sel[p] == gp_page_pkg::CODE_GP);
    end
  end

  // State register; only the hardware reset clears the shared page
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.page_sel <= '0;
      s.gp_flag <= '0;
      s.wait_req <= 1'b1;
      s.rdata <= '0;
      s.pin_src <= gp_page_pkg::RST_PIN_SRC;
      s.ctrl2 <= gp_page_pkg::RST_CTRL2;
      s.gp_out <= gp_page_pkg::RST_ZERO;
      s.gp_oe <= gp_page_pkg::RST_ZERO;
      s.micro <= gp_page_pkg::RST_ZERO;
      s.mac_mode <= gp_page_pkg::RST_ZERO;
      s.led_enh <= gp_page_pkg::RST_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // One pin cell per GPIO, field at bits 2n+1:2n
  for (genvar n = 0; n < gp_page_pkg::NUM_PINS; n++) begin : g_pin
    gpio_pin_cell u_cell (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_sel(s.pin_src[n*gp_page_pkg::FIELD_W +: gp_page_pkg::FIELD_W]),
      .out_bit(s.gp_out[n]),
      .oe_bit(s.gp_oe[n]),
      .pin_out(gpio_out[n]),
      .pin_oe(gpio_oe[n])
    );
  end

  // Outputs straight from flip-flops
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wait_req;
  assign page_is_gp = s.gp_flag;

endmodule : gp_page_regs

// *** design/gp_page_pkg.sv ***
// Constants for the shared general-purpose register page and its pin control
package gp_page_pkg;

  // Structure sizes
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int IDX_W = 5;
  localparam int REG_W = 16;
  localparam int NUM_PINS = 8;
  localparam int FIELD_W = 2;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Byte address layout: port in the top bits, word index below
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_PORT_LSB = 7;

  // Page select codes written to register 31
  localparam logic [15:0] CODE_MAIN = 16'h0000;
  localparam logic [15:0] CODE_GP = 16'h0010;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_PAGE = 5'h1f;
  localparam logic [4:0] IDX_PIN_SRC = 5'h0d;
  localparam logic [4:0] IDX_CTRL2 = 5'h0e;
  localparam logic [4:0] IDX_GP_IN = 5'h0f;
  localparam logic [4:0] IDX_GP_OUT = 5'h10;
  localparam logic [4:0] IDX_GP_OE = 5'h11;
  localparam logic [4:0] IDX_MICRO = 5'h12;
  localparam logic [4:0] IDX_MAC_MODE = 5'h13;
  localparam logic [4:0] IDX_LED_ENH = 5'h19;
  localparam logic [4:0] IDX_INT_STAT = 5'h1d;

  // Reset values
  localparam logic [15:0] RST_PIN_SRC = 16'h0000;
  localparam logic [15:0] RST_CTRL2 = 16'h2400;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // Writable bits of control 2; bit 11 mirrors the mode pin, bit 8 reads zero
  localparam logic [15:0] CTRL2_WR_MASK = 16'hf6ff;
  localparam int CTRL2_PIN_BIT = 11;
  localparam logic [15:0] GP_IN_MASK = 16'h00ff;

  // Pin source code that hands a pin to the output registers
  localparam logic [1:0] SRC_REGS = 2'h3;

endpackage : gp_page_pkg

// *** design/gpio_pin_cell.sv ***
// One GPIO pin: source select and registered drive
`timescale 1ns/1ps
module gpio_pin_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control from the shared page
  input wire logic [1:0] src_sel,
  input wire logic out_bit,
  input wire logic oe_bit,
  // Pin drive
  output logic pin_out,
  output logic pin_oe
);

  typedef struct packed {
    logic out;
    logic oe;
  } cell_t;

  cell_t s;
  cell_t next_s;

  // Only source code 11 lets the registers drive the pin
  always_comb begin
    next_s = '0;
    if (src_sel == gp_page_pkg::SRC_REGS) begin
      next_s.out = out_bit;
      next_s.oe = oe_bit;
    end
  end

  // Pin released while in reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.out;
  assign pin_oe = s.oe;

endmodule : gpio_pin_cell

// *** dv/gp_page_checker.sv ***
// Port assertions for the shared register page
`timescale 1ns/1ps
module gp_page_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] port_soft_rst,
  // Bus
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and page state
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [3:0] page_is_gp
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decoded bus fields
  logic [4:0] idx;
  logic [1:0] prt;
  logic pw, ra, rsvd;
  assign idx = avs_address[6:2];
  assign prt = avs_address[8:7];
  assign pw = avs_write && !avs_waitrequest && idx == 5'h1f && avs_byteenable[1:0] == 2'h3
    && avs_address[1:0] == 2'h0;
  assign ra = avs_read && !avs_waitrequest && avs_address[1:0] == 2'h0;
  assign rsvd = idx < 5'h0d || idx == 5'h1e || (idx > 5'h13 && idx != 5'h19 && idx < 5'h1d);
  property p_open;
    pw && avs_writedata[15:0] == 16'h0010 |=> page_is_gp[$past(prt)];
  endproperty
  a_open: assert property (p_open) else $error("page not opened");
  property p_close;
    pw && avs_writedata[15:0] == 16'h0000 |=> !page_is_gp[$past(prt)];
  endproperty
  a_close: assert property (p_close) else $error("page not closed");
  property p_closed_zero;
    ra && idx != 5'h1f && !$past(page_is_gp[prt]) |-> avs_readdata == 32'h0;
  endproperty
  a_closed_zero: assert property (p_closed_zero) else $error("closed read");
  property p_rsvd_zero;
    ra && rsvd |-> avs_readdata == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bad wait");
  property p_pins_rst;
    $past(sys_rst) |-> gpio_oe == 8'h0 && gpio_out == 8'h0;
  endproperty
  a_pins_rst: assert property (p_pins_rst) else $error("pins after reset");
  property p_soft_keep;
    port_soft_rst != 4'h0 && !avs_write && !$past(avs_write) |=> $stable(gpio_oe) && $stable(gpio_out);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset hit pins");
  property p_soft_close;
    port_soft_rst[0] && !avs_write |=> !page_is_gp[0];
  endproperty
  a_soft_close: assert property (p_soft_close) else $error("soft page");
endmodule : gp_page_checker
bind gp_page_regs gp_page_checker gp_page_checker_inst (.clk, .sys_rst, .port_soft_rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .gpio_out, .gpio_oe, .page_is_gp);

// *** dv/mgmt_master.sv ***
// Management master model on the register bus
`timescale 1ns/1ps
module mgmt_master (
  // Clock
  input wire logic clk,
  // Bus toward the page
  output logic [8:0] avs_address = 9'h0,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  output logic [3:0] avs_byteenable = 4'h0,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // One transfer, held until the wait lifts
  task automatic xfer(input logic w, input logic [1:0] p, input logic [4:0] i,
      input logic [15:0] d, input logic [3:0] be, output logic [15:0] q);
    @(posedge clk);
    avs_address <= {p, i, 2'h0};
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : mgmt_master

// *** dv/global_register_page_gpio_select_test.sv ***
// Self-checking bench for the shared register page
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module global_register_page_gpio_select_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] port_soft_rst = 4'h0;
  logic [7:0] gpio_in = 8'h5a;
  logic [15:0] int_status_in = 16'h0;
  logic coma_in = 1'b0;
  logic [8:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, page_is_gp;
  logic [7:0] gpio_out, gpio_oe;
  logic [31:0] seed = 32'he5eb;
  logic [15:0] q, src, val, oe;
  int failures = 0;
  int n_checks = 0;
  gp_page_regs gp_page_regs_inst (.clk, .sys_rst, .port_soft_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .gpio_in,
    .gpio_out, .gpio_oe, .coma_in, .int_status_in, .page_is_gp);
  mgmt_master mgmt_master_inst (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  // Random source and expected pin drive
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] pins(input logic [15:0] s, input logic [15:0] v);
    logic [7:0] e;
    for (int n = 0; n < 8; n++) e[n] = (s[2*n+:2] == 2'h3) & v[n];
    return e;
  endfunction : pins
  // Control 2 read value: writable bits kept, mode pin level mirrored
  function automatic logic [15:0] ctrl2_exp(input logic [15:0] d, input logic c);
    logic [15:0] e;
    e = d & gp_page_pkg::CTRL2_WR_MASK;
    e[gp_page_pkg::CTRL2_PIN_BIT] = c;
    return e;
  endfunction : ctrl2_exp
  // Bus helpers
  task automatic wr(input logic [1:0] p, input logic [4:0] i, input logic [15:0] d);
    mgmt_master_inst.xfer(1'b1, p, i, d, 4'hf, q);
  endtask : wr
  task automatic chk(input logic [1:0] p, input logic [4:0] i, input logic [15:0] e,
      input string n);
    mgmt_master_inst.xfer(1'b0, p, i, 16'h0, 4'hf, q);
    `CHK(n, e, q)
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    chk(0, 5'h0d, 16'h0, "closed");
    wr(0, 5'h1f, 16'h0010);
    wr(3, 5'h1f, 16'h0010);
    chk(0, 5'h0d, 16'h0, "src reset");
    chk(3, 5'h0f, {8'h0, gpio_in}, "gp in");
    `CHK("page flags", 4'h9, page_is_gp)
    coma_in <= 1'b1;
    chk(0, 5'h0e, ctrl2_exp(gp_page_pkg::RST_CTRL2, 1'b1), "ctrl2 reset");
    for (int i = 0; i < 31; i++) begin
      if (i < 13 || i == 30 || (i > 19 && i != 25 && i < 29)) begin
        seed = lfsr(seed);
        wr(0, i[4:0], seed[15:0]);
        chk(3, i[4:0], 16'h0, "reserved");
      end
    end
    for (int k = 0; k < 12; k++) begin
      repeat (16) seed = lfsr(seed);
      for (int n = 0; n < 8; n++) src[2*n+:2] = {2{seed[n]}};
      val = seed[23:8];
      oe = seed[31:16];
      gpio_in <= seed[15:8];
      int_status_in <= seed[27:12];
      wr(0, 5'h0d, src);
      wr(0, 5'h10, val);
      wr(0, 5'h11, oe);
      repeat (2) @(posedge clk);
      `CHK("pin oe", pins(src, oe), gpio_oe)
      `CHK("pin out", pins(src, val), gpio_out)
      chk(3, 5'h0d, src, "shared");
      chk(0, 5'h1d, int_status_in, "int");
      chk(1, 5'h1d, 16'h0, "other port");
      coma_in <= seed[3];
      wr(0, 5'h0e, val);
      chk(3, 5'h0e, ctrl2_exp(val, seed[3]), "ctrl2");
      wr(0, 5'h12, val);
      chk(3, 5'h12, val, "micro");
      wr(3, 5'h13, oe);
      chk(0, 5'h13, oe, "mac mode");
      wr(0, 5'h19, ~val);
      chk(3, 5'h19, ~val, "led");
    end
    // Single byte lanes merge into the stored word
    mgmt_master_inst.xfer(1'b1, 2'h0, 5'h12, 16'hffff, 4'h1, q);
    chk(3, 5'h12, {val[15:8], 8'hff}, "lane low");
    mgmt_master_inst.xfer(1'b1, 2'h3, 5'h12, 16'h0000, 4'h2, q);
    chk(0, 5'h12, 16'h00ff, "lane high");
    port_soft_rst <= 4'h1;
    @(posedge clk);
    port_soft_rst <= 4'h0;
    chk(0, 5'h0d, 16'h0, "soft closed");
    chk(3, 5'h0d, src, "soft kept");
    `CHK("soft pins", pins(src, oe), gpio_oe)
    wr(3, 5'h1f, 16'h0000);
    chk(3, 5'h0d, 16'h0, "main page");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wr(2, 5'h1f, 16'h0010);
    chk(2, 5'h0d, 16'h0, "hard cleared");
    chk(2, 5'h0e, ctrl2_exp(gp_page_pkg::RST_CTRL2, coma_in), "ctrl2 cleared");
    `CHK("hard pins", 8'h0, gpio_oe)
    stop_test;
  end
endmodule : global_register_page_gpio_select_test
